// file: dmsia_pkg.sv
// What this block does
// RULE1 - Every location holds one eight-bit byte
// RULE2 - Low half of sector offsets is SFR
// RULE3 - Upper half is RAM, four sectors
// RULE4 - Same offset, same category in every sector
// RULE5 - High pointer picks sector, low picks byte
// RULE6 - Extended address: sector bits plus byte
// RULE7 - Standard direct reaches only sector zero
// RULE8 - RAM readable, writable, single bit ops
// RULE9 - Protected SFRs ignore program writes
// RULE10 - Unused SFR addresses read zero
// RULE11 - Indirect ports redirect to pointer target
// RULE12 - First indirect port reaches sector zero only
// RULE13 - Second, third ports reach any sector
// RULE14 - Indirect access to indirect port: nothing
// RULE15 - Effective address is pointer value
// RULE16 - Four sectors; others read zero
package dmsia_pkg;

    // Widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 10;
    localparam int SECT_W = 2;
    localparam int OFF_W  = 8;
    localparam int SFR_W  = 7;
    localparam int RAM_AW = 9;
    localparam int BIT_W  = 3;

    // Sector and area boundaries
    localparam logic [SECT_W-1:0] SECTOR_ZERO = 2'h0;
    localparam logic [OFF_W-1:0]  GP_BASE     = 8'h80;
    localparam logic [DATA_W-1:0] ZERO_BYTE   = 8'h00;
    localparam logic [DATA_W-1:0] PTR_RESET   = 8'h00;

    // Register offsets in sector zero
    localparam logic [OFF_W-1:0] OFF_INDIRECT_PORT_SECTOR_ZERO = 8'h00;
    localparam logic [OFF_W-1:0] OFF_POINTER_SECTOR_ZERO       = 8'h01;
    localparam logic [OFF_W-1:0] OFF_INDIRECT_PORT_ONE         = 8'h02;
    localparam logic [OFF_W-1:0] OFF_POINTER_ONE_LOW           = 8'h03;
    localparam logic [OFF_W-1:0] OFF_POINTER_ONE_HIGH          = 8'h04;
    localparam logic [OFF_W-1:0] OFF_INDIRECT_PORT_TWO         = 8'h0b;
    localparam logic [OFF_W-1:0] OFF_POINTER_TWO_LOW           = 8'h0c;
    localparam logic [OFF_W-1:0] OFF_POINTER_TWO_HIGH          = 8'h0d;

    // Pointer register indices in the local pointer file
    localparam int NUM_PTR = 5;
    localparam logic [2:0] PTR_ZERO     = 3'h0;
    localparam logic [2:0] PTR_ONE_LOW  = 3'h1;
    localparam logic [2:0] PTR_ONE_HIGH = 3'h2;
    localparam logic [2:0] PTR_TWO_LOW  = 3'h3;
    localparam logic [2:0] PTR_TWO_HIGH = 3'h4;

    // Control sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACC  = 2'b01,
        ST_WRB  = 2'b10
    } dmsia_state_type;

    // Kind of location an access resolves to
    typedef enum logic [1:0] {
        TGT_NONE = 2'b00,
        TGT_RAM  = 2'b01,
        TGT_SFR  = 2'b10,
        TGT_PTR  = 2'b11
    } dmsia_tgt_type;

    // Which indirect port an offset names
    typedef enum logic [1:0] {
        PORT_NONE = 2'b00,
        PORT_ZERO = 2'b01,
        PORT_ONE  = 2'b10,
        PORT_TWO  = 2'b11
    } dmsia_port_type;

endpackage

// file: dmsia_gp_ram.sv
`timescale 1ns/100ps
// General purpose byte store, all sectors, combinational read
module dmsia_gp_ram
(
    // Clock
    input  wire logic                             core_clk,
    // Write side
    input  wire logic                             wr_en,
    input  wire logic [dmsia_pkg::RAM_AW-1:0]     wr_addr,
    input  wire logic [dmsia_pkg::DATA_W-1:0]     wr_data,
    // Read side
    input  wire logic [dmsia_pkg::RAM_AW-1:0]     rd_addr,
    output logic      [dmsia_pkg::DATA_W-1:0]     rd_data
);

    // One byte per location; no reset, contents are undefined at power-up
    logic [dmsia_pkg::DATA_W-1:0] mem [0:(1 << dmsia_pkg::RAM_AW)-1];

    // Byte write, whole location at once
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data; // see RULE1
        end
    end

    // Read path is asynchronous so a read-modify-write fits one cycle
    assign rd_data = mem[rd_addr];

endmodule

// file: dmsia_data_memory.sv
`timescale 1ns/100ps
// Data memory with sector decode, pointer file and indirect ports
module dmsia_data_memory
(
    // Clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            nrst,
    // CPU request
    input  wire logic                            cpu_req,
    input  wire logic                            cpu_wr,
    input  wire logic                            cpu_ext,
    input  wire logic [dmsia_pkg::ADDR_W-1:0]    cpu_addr,
    input  wire logic [dmsia_pkg::DATA_W-1:0]    cpu_wdata,
    input  wire logic                            cpu_bit_op,
    input  wire logic                            cpu_bit_val,
    input  wire logic [dmsia_pkg::BIT_W-1:0]     cpu_bit_idx,
    // CPU answer
    output logic                                 cpu_ready,
    output logic                                 cpu_done,
    output logic      [dmsia_pkg::DATA_W-1:0]    cpu_rdata,
    // Special function register port toward peripherals
    output logic      [dmsia_pkg::SFR_W-1:0]     sfr_addr,
    output logic                                 sfr_rd,
    output logic                                 sfr_wr,
    output logic      [dmsia_pkg::DATA_W-1:0]    sfr_wdata,
    input  wire logic [dmsia_pkg::DATA_W-1:0]    sfr_rdata,
    input  wire logic                            sfr_hit,
    input  wire logic                            sfr_ro
);

    // Sequencer
    dmsia_pkg::dmsia_state_type state_r;      // Current state
    dmsia_pkg::dmsia_state_type state_nxt;    // Next state

    // Resolved access captured at acceptance
    dmsia_pkg::dmsia_tgt_type       tgt_r;        // Target kind
    logic [dmsia_pkg::SECT_W-1:0]   sect_r;       // Effective sector
    logic [dmsia_pkg::OFF_W-1:0]    off_r;        // Effective offset
    logic [2:0]                     ptr_idx_r;    // Pointer file index
    logic                           wr_r;         // Access is a write
    logic                           bit_op_r;     // Single bit operation
    logic                           bit_val_r;    // Bit value to place
    logic [dmsia_pkg::BIT_W-1:0]    bit_idx_r;    // Bit position
    logic [dmsia_pkg::DATA_W-1:0]   wdata_r;      // Write byte

    // Pointer file
    logic [dmsia_pkg::DATA_W-1:0]   ptr_r [0:dmsia_pkg::NUM_PTR-1];

    // Output flops
    logic                           cpu_ready_r;
    logic                           cpu_done_r;
    logic [dmsia_pkg::DATA_W-1:0]   cpu_rdata_r;
    logic [dmsia_pkg::SFR_W-1:0]    sfr_addr_r;
    logic                           sfr_rd_r;
    logic                           sfr_wr_r;
    logic [dmsia_pkg::DATA_W-1:0]   sfr_wdata_r;

    // Combinational decode
    logic [dmsia_pkg::SECT_W-1:0]   d_sect;       // Direct sector
    logic [dmsia_pkg::OFF_W-1:0]    d_off;        // Direct offset
    dmsia_pkg::dmsia_port_type      d_port;       // Indirect port named directly
    logic [dmsia_pkg::SECT_W-1:0]   e_sect;       // Effective sector
    logic [dmsia_pkg::OFF_W-1:0]    e_off;        // Effective offset
    logic                           e_valid;      // Sector exists
    dmsia_pkg::dmsia_tgt_type       e_tgt;        // Effective target kind
    logic [3:0]                     e_ptr;        // Pointer index, bit 3 a hit
    logic                           accept;       // Request taken this edge

    // Access stage data
    logic [dmsia_pkg::DATA_W-1:0]   ram_rdata;    // Current RAM byte
    logic [dmsia_pkg::DATA_W-1:0]   old_byte;     // Byte before the access
    logic [dmsia_pkg::DATA_W-1:0]   new_byte;     // Byte after the access
    logic                           ram_we;       // RAM write strobe
    logic                           sfr_go_wr;    // SFR write may proceed

    // Names the indirect port at an offset, if any
    function automatic dmsia_pkg::dmsia_port_type port_of
    (
        input logic [dmsia_pkg::OFF_W-1:0] off
    );
        dmsia_pkg::dmsia_port_type p;
        p = dmsia_pkg::PORT_NONE;
        if (off == dmsia_pkg::OFF_INDIRECT_PORT_SECTOR_ZERO)
            p = dmsia_pkg::PORT_ZERO;
        else if (off == dmsia_pkg::OFF_INDIRECT_PORT_ONE)
            p = dmsia_pkg::PORT_ONE;
        else if (off == dmsia_pkg::OFF_INDIRECT_PORT_TWO)
            p = dmsia_pkg::PORT_TWO;
        return p;
    endfunction

    // Maps a sector-zero offset to a pointer file index; bit 3 flags a hit
    function automatic logic [3:0] ptr_of
    (
        input logic [dmsia_pkg::OFF_W-1:0] off
    );
        logic [3:0] r;
        r = 4'h0;
        case (off)
            dmsia_pkg::OFF_POINTER_SECTOR_ZERO: r = {1'b1, dmsia_pkg::PTR_ZERO};
            dmsia_pkg::OFF_POINTER_ONE_LOW:     r = {1'b1, dmsia_pkg::PTR_ONE_LOW};
            dmsia_pkg::OFF_POINTER_ONE_HIGH:    r = {1'b1, dmsia_pkg::PTR_ONE_HIGH};
            dmsia_pkg::OFF_POINTER_TWO_LOW:     r = {1'b1, dmsia_pkg::PTR_TWO_LOW};
            dmsia_pkg::OFF_POINTER_TWO_HIGH:    r = {1'b1, dmsia_pkg::PTR_TWO_HIGH};
            default:                            r = 4'h0;
        endcase
        return r;
    endfunction

    // Whole byte write or single bit set/clear
    function automatic logic [dmsia_pkg::DATA_W-1:0] merge_byte
    (
        input logic [dmsia_pkg::DATA_W-1:0] old,
        input logic [dmsia_pkg::DATA_W-1:0] wdata,
        input logic                         bit_op,
        input logic                         bit_val,
        input logic [dmsia_pkg::BIT_W-1:0]  bit_idx
    );
        logic [dmsia_pkg::DATA_W-1:0] r;
        r = wdata;
        if (bit_op)
        begin
            r = old;
            r[bit_idx] = bit_val;
        end
        return r;
    endfunction

    assign accept = (state_r == dmsia_pkg::ST_IDLE) && cpu_req;

    // Direct address: standard instructions see sector zero only
    always_comb
    begin
        d_sect = cpu_ext ? cpu_addr[dmsia_pkg::ADDR_W-1:dmsia_pkg::OFF_W]
                         : dmsia_pkg::SECTOR_ZERO; // see RULE6 see RULE7
        d_off  = cpu_addr[dmsia_pkg::OFF_W-1:0];   // see RULE6
        d_port = dmsia_pkg::PORT_NONE;
        // Ports exist only in the sector-zero SFR area
        if ((d_sect == dmsia_pkg::SECTOR_ZERO) && (d_off < dmsia_pkg::GP_BASE))
        begin
            d_port = port_of(d_off); // see RULE11
        end
    end

    // Redirect through the paired pointer when a port is named
    always_comb
    begin
        e_sect  = d_sect;
        e_off   = d_off;
        e_valid = 1'b1;
        case (d_port)
            dmsia_pkg::PORT_ZERO:
            begin
                // Single-byte pointer, sector pinned to zero
                e_sect = dmsia_pkg::SECTOR_ZERO;                 // see RULE12
                e_off  = ptr_r[dmsia_pkg::PTR_ZERO];              // see RULE15
            end
            dmsia_pkg::PORT_ONE:
            begin
                // High byte picks sector, low byte picks location
                e_sect  = ptr_r[dmsia_pkg::PTR_ONE_HIGH][dmsia_pkg::SECT_W-1:0]; // see RULE5
                e_off   = ptr_r[dmsia_pkg::PTR_ONE_LOW];                        // see RULE13
                e_valid = (ptr_r[dmsia_pkg::PTR_ONE_HIGH]
                          [dmsia_pkg::DATA_W-1:dmsia_pkg::SECT_W] == '0);       // see RULE16
            end
            dmsia_pkg::PORT_TWO:
            begin
                e_sect  = ptr_r[dmsia_pkg::PTR_TWO_HIGH][dmsia_pkg::SECT_W-1:0]; // see RULE5
                e_off   = ptr_r[dmsia_pkg::PTR_TWO_LOW];                        // see RULE13
                e_valid = (ptr_r[dmsia_pkg::PTR_TWO_HIGH]
                          [dmsia_pkg::DATA_W-1:dmsia_pkg::SECT_W] == '0);       // see RULE16
            end
            default:
            begin
                // Plain direct access keeps its own address
                e_valid = 1'b1;
            end
        endcase
    end

    // Classify the effective location
    always_comb
    begin
        e_tgt = dmsia_pkg::TGT_NONE;
        e_ptr = ptr_of(e_off);
        if (!e_valid)
        begin
            // Pointer names a sector that does not exist
            e_tgt = dmsia_pkg::TGT_NONE; // see RULE16
        end
        else if (e_off >= dmsia_pkg::GP_BASE)
        begin
            // Upper half is RAM in every sector
            e_tgt = dmsia_pkg::TGT_RAM; // see RULE3 see RULE4
        end
        else if (e_sect != dmsia_pkg::SECTOR_ZERO)
        begin
            // Other sectors hold no SFRs here; reads give zero
            e_tgt = dmsia_pkg::TGT_NONE; // see RULE10
        end
        else if (port_of(e_off) != dmsia_pkg::PORT_NONE)
        begin
            // Only reachable by redirect: ports have no storage
            e_tgt = dmsia_pkg::TGT_NONE; // see RULE14
        end
        else if (e_ptr[3])
        begin
            e_tgt = dmsia_pkg::TGT_PTR;
        end
        else
        begin
            // Lower half of sector zero is the SFR area
            e_tgt = dmsia_pkg::TGT_SFR; // see RULE2
        end
    end

    // Capture the resolved access
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tgt_r     <= dmsia_pkg::TGT_NONE;
            sect_r    <= dmsia_pkg::SECTOR_ZERO;
            off_r     <= '0;
            ptr_idx_r <= dmsia_pkg::PTR_ZERO;
            wr_r      <= 1'b0;
            bit_op_r  <= 1'b0;
            bit_val_r <= 1'b0;
            bit_idx_r <= '0;
            wdata_r   <= dmsia_pkg::ZERO_BYTE;
        end
        else if (accept)
        begin
            tgt_r     <= e_tgt;
            sect_r    <= e_sect;
            off_r     <= e_off;
            ptr_idx_r <= e_ptr[2:0];
            wr_r      <= cpu_wr;
            bit_op_r  <= cpu_bit_op;
            bit_val_r <= cpu_bit_val;
            bit_idx_r <= cpu_bit_idx;
            wdata_r   <= cpu_wdata;
        end
    end

    // Current byte of the target; absent locations read zero
    always_comb
    begin
        case (tgt_r)
            dmsia_pkg::TGT_RAM: old_byte = ram_rdata;
            dmsia_pkg::TGT_PTR: old_byte = ptr_r[ptr_idx_r];
            dmsia_pkg::TGT_SFR: old_byte = sfr_hit ? sfr_rdata
                                                   : dmsia_pkg::ZERO_BYTE; // see RULE10
            default:            old_byte = dmsia_pkg::ZERO_BYTE;           // see RULE14
        endcase
        new_byte = merge_byte(old_byte, wdata_r, bit_op_r, bit_val_r, bit_idx_r); // see RULE8
    end

    assign ram_we    = (state_r == dmsia_pkg::ST_ACC) && wr_r
                       && (tgt_r == dmsia_pkg::TGT_RAM); // see RULE8
    // Protected or unused SFRs skip the write phase
    assign sfr_go_wr = (state_r == dmsia_pkg::ST_ACC) && wr_r
                       && (tgt_r == dmsia_pkg::TGT_SFR)
                       && sfr_hit && !sfr_ro; // see RULE9

    // General purpose RAM, indexed by sector and half offset
    dmsia_gp_ram u_gp_ram
    (
        .core_clk (core_clk),
        .wr_en    (ram_we),
        .wr_addr  ({sect_r, off_r[dmsia_pkg::OFF_W-2:0]}),
        .wr_data  (new_byte),
        .rd_addr  ({sect_r, off_r[dmsia_pkg::OFF_W-2:0]}),
        .rd_data  (ram_rdata)
    );

    // Pointer file; written only through its own sector-zero offsets
    genvar g;
    generate
        for (g = 0; g < dmsia_pkg::NUM_PTR; g++)
        begin : g_ptr
            always_ff @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    ptr_r[g] <= dmsia_pkg::PTR_RESET;
                end
                else if ((state_r == dmsia_pkg::ST_ACC) && wr_r
                         && (tgt_r == dmsia_pkg::TGT_PTR) && (ptr_idx_r == 3'(g)))
                begin
                    ptr_r[g] <= new_byte;
                end
            end
        end
    endgenerate

    // Next state: SFR writes need a second cycle after the read
    always_comb
    begin
        case (state_r)
            dmsia_pkg::ST_IDLE: state_nxt = cpu_req ? dmsia_pkg::ST_ACC : dmsia_pkg::ST_IDLE;
            dmsia_pkg::ST_ACC:  state_nxt = sfr_go_wr ? dmsia_pkg::ST_WRB : dmsia_pkg::ST_IDLE;
            dmsia_pkg::ST_WRB:  state_nxt = dmsia_pkg::ST_IDLE;
            default:            state_nxt = dmsia_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            state_r <= dmsia_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // CPU handshake flops
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cpu_ready_r <= 1'b1;
            cpu_done_r  <= 1'b0;
        end
        else
        begin
            cpu_ready_r <= (state_nxt == dmsia_pkg::ST_IDLE);
            cpu_done_r  <= (state_r != dmsia_pkg::ST_IDLE)
                           && (state_nxt == dmsia_pkg::ST_IDLE);
        end
    end

    // Read byte: value before any write, always a full byte
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            cpu_rdata_r <= dmsia_pkg::ZERO_BYTE;
        else if (state_r == dmsia_pkg::ST_ACC)
            cpu_rdata_r <= old_byte; // see RULE1
    end

    // SFR address and read strobe, issued for every SFR access
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sfr_addr_r <= '0;
            sfr_rd_r   <= 1'b0;
        end
        else
        begin
            sfr_rd_r <= accept && (e_tgt == dmsia_pkg::TGT_SFR);
            if (accept)
                sfr_addr_r <= e_off[dmsia_pkg::SFR_W-1:0];
        end
    end

    // SFR write strobe; merged byte allows SFR bit ops
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sfr_wr_r    <= 1'b0;
            sfr_wdata_r <= dmsia_pkg::ZERO_BYTE;
        end
        else
        begin
            sfr_wr_r <= sfr_go_wr; // see RULE9
            if (sfr_go_wr)
                sfr_wdata_r <= new_byte;
        end
    end

    // Outputs straight from flops
    assign cpu_ready = cpu_ready_r;
    assign cpu_done  = cpu_done_r;
    assign cpu_rdata = cpu_rdata_r;
    assign sfr_addr  = sfr_addr_r;
    assign sfr_rd    = sfr_rd_r;
    assign sfr_wr    = sfr_wr_r;
    assign sfr_wdata = sfr_wdata_r;

endmodule

// file: dmsia_sfr_model.sv
`timescale 1ns/100ps
// Peripheral stand-in behind the SFR port
module dmsia_sfr_model
(
    // Clock
    input  wire logic       core_clk,
    // Strobes from the memory
    input  wire logic [6:0] sfr_addr,
    input  wire logic       sfr_rd,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    // Answers to the memory
    output logic      [7:0] sfr_rdata,
    output logic            sfr_hit,
    output logic            sfr_ro
);
    // Register bytes, only 00..3f implemented
    logic [7:0] regs [0:127];

    // One protected byte with a known value
    initial
    begin
        for (int i = 0; i < 128; i++)
            regs[i] = 8'h00;
        regs[7'h0a] = 8'h5a;
    end

    // Offsets from 40 up are unused
    assign sfr_hit = sfr_addr < 7'h40;
    // Read-only byte
    assign sfr_ro = sfr_addr == 7'h0a;
    // Unused offsets return junk; idle bus shows inverse
    assign sfr_rdata = sfr_rd ? (sfr_hit ? regs[sfr_addr] : 8'hc3) : ~regs[sfr_addr];

    // Writes land on writable bytes only
    always @(posedge core_clk)
    begin
        if (sfr_wr && sfr_hit && !sfr_ro)
            regs[sfr_addr] <= sfr_wdata;
    end
endmodule

// file: dmsia_checker.sv
`timescale 1ns/100ps
// Watches the CPU and SFR ports
module dmsia_checker
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       nrst,
    // CPU side
    input wire logic       cpu_req,
    input wire logic       cpu_ext,
    input wire logic [9:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic       cpu_bit_op,
    input wire logic       cpu_ready,
    input wire logic       cpu_done,
    input wire logic [7:0] cpu_rdata,
    // SFR side
    input wire logic [6:0] sfr_addr,
    input wire logic       sfr_rd,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sfr_hit,
    input wire logic       sfr_ro
);
    logic       acc;       // Request taken this edge
    logic       loc;       // Offset held inside the block
    logic       ptr;       // Offset of a pointer
    logic       sec0;      // Access lands in sector zero
    logic [6:0] off_r;     // Offset of the last taken request
    logic [7:0] sfr_cap_r; // SFR byte of the access

    assign acc = cpu_req && cpu_ready;
    assign ptr = cpu_addr[7:0] inside {8'h01, 8'h03, 8'h04, 8'h0c, 8'h0d};
    assign loc = ptr || cpu_addr[7:0] inside {8'h00, 8'h02, 8'h0b};
    assign sec0 = !cpu_ext || cpu_addr[9:8] == 2'h0;

    // Captures for the checks
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            off_r <= 7'h00;
            sfr_cap_r <= 8'h00;
        end
        else
        begin
            if (acc)
                off_r <= cpu_addr[6:0];
            if (sfr_rd)
                sfr_cap_r <= sfr_rdata;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_quiet;
        !sfr_rd ##1 !sfr_wr;
    endsequence
    sequence s_zero_done;
        cpu_done && cpu_rdata == 8'h00;
    endsequence

    chk_sfr_strobe: assert property (acc && !cpu_addr[7] && !loc && sec0 |=> sfr_rd && sfr_addr == off_r)
        else $error("SFR strobe or address wrong");
    chk_ram_quiet: assert property (acc && cpu_addr[7] |=> s_quiet)
        else $error("RAM access touched SFR port");
    chk_sector_none: assert property (acc && !sec0 && !cpu_addr[7] |=> !sfr_rd ##1 s_zero_done)
        else $error("Upper sector SFR area not empty");
    chk_pointer_local: assert property (acc && ptr && sec0 |=> s_quiet)
        else $error("Pointer access left the block");
    chk_ro_blocked: assert property (sfr_rd && (sfr_ro || !sfr_hit) |=> !sfr_wr)
        else $error("Protected or unused SFR written");
    chk_unused_zero: assert property (sfr_rd && !sfr_hit |=> s_zero_done)
        else $error("Unused SFR not read as zero");
    chk_sfr_readback: assert property (sfr_rd && sfr_hit |=> ##[0:1] (cpu_done && cpu_rdata == sfr_cap_r))
        else $error("SFR byte not returned");
    chk_write_data: assert property (sfr_wr && !cpu_bit_op |-> sfr_wdata == cpu_wdata ##1 cpu_done)
        else $error("SFR write byte wrong");
    chk_done_bound: assert property (acc |=> (!cpu_ready && !cpu_done) ##[1:2] cpu_done)
        else $error("Access too slow");
endmodule

bind dmsia_data_memory dmsia_checker u_chk (.core_clk(core_clk), .nrst(nrst),
    .cpu_req(cpu_req), .cpu_ext(cpu_ext), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_bit_op(cpu_bit_op), .cpu_ready(cpu_ready), .cpu_done(cpu_done),
    .cpu_rdata(cpu_rdata), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .sfr_ro(sfr_ro));

// file: data_memory_sector_indirect_access_tb.sv
`timescale 1ns/100ps
// CPU access sequences with expected bytes
module data_memory_sector_indirect_access_tb;
    // CPU drive
    logic       core_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       cpu_req = 1'b0;
    logic       cpu_wr = 1'b0;
    logic       cpu_ext = 1'b0;
    logic [9:0] cpu_addr = 10'h000;
    logic [7:0] cpu_wdata = 8'h00;
    logic       cpu_bit_op = 1'b0;
    logic       cpu_bit_val = 1'b0;
    logic [2:0] cpu_bit_idx = 3'h0;
    // Design answers
    logic       cpu_ready, cpu_done, sfr_rd, sfr_wr, sfr_hit, sfr_ro;
    logic [7:0] cpu_rdata, sfr_wdata, sfr_rdata, q;
    logic [6:0] sfr_addr;
    int         mismatches = 0;
    int         samples_checked = 0;

    always #2.5 core_clk = ~core_clk;

    dmsia_data_memory dut (.core_clk(core_clk), .nrst(nrst), .cpu_req(cpu_req),
        .cpu_wr(cpu_wr), .cpu_ext(cpu_ext), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_bit_op(cpu_bit_op), .cpu_bit_val(cpu_bit_val), .cpu_bit_idx(cpu_bit_idx),
        .cpu_ready(cpu_ready), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata),
        .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .sfr_ro(sfr_ro));
    dmsia_sfr_model u_sfr (.core_clk(core_clk), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .sfr_ro(sfr_ro));

    // Compares one byte and counts it
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict
    task automatic tally_and_finish;
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One access, done awaited with a bound
    task automatic acc(input logic w, input logic x, input logic [9:0] a,
        input logic [7:0] d, input logic b, input logic v, input logic [2:0] i);
        int n = 0;
        @(negedge core_clk);
        cpu_req = 1'b1;
        cpu_wr = w;
        cpu_ext = x;
        cpu_addr = a;
        cpu_wdata = d;
        cpu_bit_op = b;
        cpu_bit_val = v;
        cpu_bit_idx = i;
        @(negedge core_clk);
        cpu_req = 1'b0;
        while (cpu_done !== 1'b1 && n < 8)
        begin
            @(negedge core_clk);
            n++;
        end
        check({7'h00, cpu_done}, 8'h01);
        q = cpu_rdata;
    endtask

    // Plain byte write
    task automatic wr(input logic x, input logic [9:0] a, input logic [7:0] d);
        acc(1'b1, x, a, d, 1'b0, 1'b0, 3'h0);
    endtask

    // Byte read and compare
    task automatic rd(input logic x, input logic [9:0] a, input logic [7:0] e);
        acc(1'b0, x, a, 8'h00, 1'b0, 1'b0, 3'h0);
        check(q, e);
    endtask

    initial
    begin
        repeat (16) @(negedge core_clk);
        nrst = 1'b1;
        // Upper offsets differ per sector
        for (int s = 0; s < 4; s++)
        begin
            wr(1'b1, {s[1:0], 8'h80}, 8'h10 + 8'(s));
            wr(1'b1, {s[1:0], 8'hff}, 8'he0 + 8'(s));
        end
        for (int s = 0; s < 4; s++)
        begin
            rd(1'b1, {s[1:0], 8'h80}, 8'h10 + 8'(s));
            rd(1'b1, {s[1:0], 8'hff}, 8'he0 + 8'(s));
        end
        // Standard form drops sector bits
        wr(1'b0, 10'h380, 8'h5c);
        rd(1'b1, 10'h080, 8'h5c);
        rd(1'b1, 10'h380, 8'h13);
        // Sector one low half is empty, no alias
        wr(1'b1, 10'h105, 8'hff);
        rd(1'b1, 10'h105, 8'h00);
        rd(1'b0, 10'h005, 8'h00);
        // SFR area: writable, protected, unused
        wr(1'b0, 10'h005, 8'h3c);
        rd(1'b1, 10'h005, 8'h3c);
        wr(1'b0, 10'h00a, 8'hff);
        rd(1'b0, 10'h00a, 8'h5a);
        wr(1'b0, 10'h07e, 8'h66);
        rd(1'b0, 10'h07e, 8'h00);
        // First port stays in sector zero
        wr(1'b1, 10'h185, 8'h77);
        wr(1'b0, 10'h001, 8'h85);
        wr(1'b0, 10'h000, 8'h11);
        rd(1'b1, 10'h085, 8'h11);
        rd(1'b1, 10'h185, 8'h77);
        rd(1'b0, 10'h001, 8'h85);
        // Second and third ports reach upper sectors
        wr(1'b0, 10'h004, 8'h02);
        wr(1'b0, 10'h003, 8'ha0);
        wr(1'b0, 10'h002, 8'h22);
        rd(1'b1, 10'h2a0, 8'h22);
        wr(1'b0, 10'h00d, 8'h03);
        wr(1'b0, 10'h00c, 8'hb0);
        wr(1'b0, 10'h00b, 8'h33);
        rd(1'b1, 10'h3b0, 8'h33);
        // Redirect to an SFR, then port to port
        wr(1'b0, 10'h004, 8'h00);
        wr(1'b0, 10'h003, 8'h05);
        rd(1'b0, 10'h002, 8'h3c);
        wr(1'b0, 10'h001, 8'h02);
        wr(1'b0, 10'h000, 8'hee);
        rd(1'b0, 10'h000, 8'h00);
        rd(1'b0, 10'h005, 8'h3c);
        // Single bit set and clear, old byte returned
        wr(1'b1, 10'h3c0, 8'h00);
        acc(1'b1, 1'b1, 10'h3c0, 8'h00, 1'b1, 1'b1, 3'h7);
        check(q, 8'h00);
        rd(1'b1, 10'h3c0, 8'h80);
        wr(1'b1, 10'h3c0, 8'hff);
        acc(1'b1, 1'b1, 10'h3c0, 8'h00, 1'b1, 1'b0, 3'h0);
        rd(1'b1, 10'h3c0, 8'hfe);
        // High pointer past four sectors: nothing
        wr(1'b0, 10'h004, 8'h04);
        wr(1'b0, 10'h003, 8'h80);
        wr(1'b0, 10'h002, 8'h99);
        rd(1'b0, 10'h002, 8'h00);
        rd(1'b1, 10'h080, 8'h5c);
        tally_and_finish;
    end

    // About 60 accesses of 3-4 cycles; 20 us is ample
    initial
    begin
        #20000;
        mismatches++;
        tally_and_finish;
    end
endmodule
